// file: design/adc_input_ref_clock_select.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module adc_input_ref_clock_select
    import adc_sel_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_ref_clk,
    input  wire logic              i_sys_rst,
    // APB slave.
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Voltage monitor enables from logic on this clock.
    input  wire logic              i_low_voltage_reset_en,
    input  wire logic              i_low_voltage_detect_en,
    // Analog front end controls.
    output logic                   o_bandgap_on,
    output logic                   o_bandgap_to_conv,
    output logic                   o_bandgap_routed,
    output logic [NUM_CHAN-1:0]    o_channel_connect,
    output logic                   o_ref_pin_select,
    output logic                   o_conv_power_down,
    output logic                   o_conv_clk_tick,
    // Shared pin controls.
    output logic [NUM_CHAN-1:0]    o_pin_analog,
    output logic [NUM_CHAN-1:0]    o_pin_pull_high_cut
);

    typedef struct packed {
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic                internal_ref_channel_sel;
        logic                bandgap_enable;
        logic                ref_source_sel;
        logic [DIV_W-1:0]    conv_clock_div_sel;
        logic [NUM_CHAN-1:0] analog_pin_enable;
        logic                converter_power_down;
        logic [CHAN_W-1:0]   channel_sel;
        logic                bandgap_on;
        logic                bandgap_to_conv;
        logic                bandgap_routed;
        logic [NUM_CHAN-1:0] channel_connect;
        logic                ref_pin_select;
        logic [NUM_CHAN-1:0] pin_analog;
        logic [NUM_CHAN-1:0] pin_pull_high_cut;
        logic                conv_power_down;
    } state_t;

    localparam state_t STATE_RST = '{
        pready:                   1'b0,
        pslverr:                  1'b0,
        prdata:                   32'h0000_0000,
        internal_ref_channel_sel: CFG2_RST[CFG2_INT_REF_BIT],
        bandgap_enable:           CFG2_RST[CFG2_BG_EN_BIT],
        ref_source_sel:           CFG2_RST[CFG2_REF_SRC_BIT],
        conv_clock_div_sel:       CFG2_RST[CFG2_DIV_LSB +: DIV_W],
        analog_pin_enable:        PIN_RST,
        converter_power_down:     CFG1_RST[CFG1_PD_BIT],
        channel_sel:              CFG1_RST[CFG1_CHAN_LSB +: CHAN_W],
        bandgap_on:               1'b0,
        bandgap_to_conv:          1'b0,
        bandgap_routed:           1'b0,
        channel_connect:          8'h00,
        ref_pin_select:           1'b0,
        pin_analog:               PIN_RST,
        pin_pull_high_cut:        PIN_RST,
        conv_power_down:          1'b1
    };

    state_t              q;
    state_t              d;
    logic                setup;
    logic                access;
    logic                addr_hit;
    logic [7:0]          cfg2_byte;
    logic [7:0]          cfg1_byte;
    logic [31:0]         stat_word;
    logic [31:0]         read_word;
    logic [NUM_CHAN-1:0] chan_want;

    conv_clk_if clk_bus ();

    conv_clk_div u_conv_clk_div (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .clk_bus   (clk_bus.div)
    );

    assign clk_bus.div_sel = q.conv_clock_div_sel;
    assign clk_bus.run = !q.converter_power_down;

    // Each input channel is connected only when selected, assigned as an
    // analog pin, not displaced by the bandgap or the reference pin, and
    // the converter is powered.
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        always_comb begin
            chan_want[ch] = !q.internal_ref_channel_sel
                && (q.channel_sel == CHAN_W'(ch))
                && q.analog_pin_enable[ch]
                && !(q.ref_source_sel && ch == REF_PIN_CHAN)
                && !q.converter_power_down;
        end
    end

    always_comb begin
        // Unimplemented bits five and three are wired to zero.
        cfg2_byte = {q.internal_ref_channel_sel, q.bandgap_enable, 1'b0,
                     q.ref_source_sel, 1'b0, q.conv_clock_div_sel};
        cfg1_byte = 8'h00;
        cfg1_byte[CFG1_PD_BIT] = q.converter_power_down;
        cfg1_byte[CFG1_CHAN_LSB +: CHAN_W] = q.channel_sel;
        stat_word = 32'h0000_0000;
        stat_word[STAT_BG_ON_BIT] = q.bandgap_on;
        stat_word[STAT_BG_ROUTE_BIT] = q.bandgap_routed;
        stat_word[STAT_REF_PIN_BIT] = q.ref_pin_select;
        stat_word[STAT_PD_BIT] = q.conv_power_down;
        stat_word[STAT_CONN_LSB +: NUM_CHAN] = q.channel_connect;
        addr_hit = 1'b1;
        unique case (i_paddr)
            CFG2_ADDR: begin
                read_word = {24'h00_0000, cfg2_byte};
            end
            PIN_ADDR: begin
                read_word = {24'h00_0000, q.analog_pin_enable};
            end
            CFG1_ADDR: begin
                read_word = {24'h00_0000, cfg1_byte};
            end
            STAT_ADDR: begin
                read_word = stat_word;
            end
            default: begin
                read_word = 32'h0000_0000;
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        d = q;
        setup = i_psel && !i_penable;
        access = i_psel && i_penable && q.pready;
        // Zero wait state: the answer is prepared during the setup cycle.
        d.pready = 1'b1;
        if (setup) begin
            d.pslverr = !addr_hit;
            d.prdata = i_pwrite ? 32'h0000_0000 : read_word;
        end
        if (access && i_pwrite) begin
            unique case (i_paddr)
                CFG2_ADDR: begin
                    d.internal_ref_channel_sel = i_pwdata[CFG2_INT_REF_BIT];
                    d.bandgap_enable = i_pwdata[CFG2_BG_EN_BIT];
                    d.ref_source_sel = i_pwdata[CFG2_REF_SRC_BIT];
                    d.conv_clock_div_sel = i_pwdata[CFG2_DIV_LSB +: DIV_W];
                end
                PIN_ADDR: begin
                    d.analog_pin_enable = i_pwdata[NUM_CHAN-1:0];
                end
                CFG1_ADDR: begin
                    d.converter_power_down = i_pwdata[CFG1_PD_BIT];
                    d.channel_sel = i_pwdata[CFG1_CHAN_LSB +: CHAN_W];
                end
                default: begin
                end
            endcase
        end

        // The bandgap runs while the converter asks for it or either
        // voltage monitor needs it; otherwise it is shut off to save power.
        d.bandgap_on = (q.bandgap_enable && !q.converter_power_down)
            || i_low_voltage_reset_en || i_low_voltage_detect_en;
        d.bandgap_to_conv = q.bandgap_enable && !q.converter_power_down;
        d.bandgap_routed = q.internal_ref_channel_sel && !q.converter_power_down;
        d.channel_connect = chan_want;
        d.ref_pin_select = q.ref_source_sel;
        d.pin_analog = q.analog_pin_enable;
        d.pin_pull_high_cut = q.analog_pin_enable;
        d.conv_power_down = q.converter_power_down;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign o_prdata = q.prdata;
    assign o_pready = q.pready;
    assign o_pslverr = q.pslverr;
    assign o_bandgap_on = q.bandgap_on;
    assign o_bandgap_to_conv = q.bandgap_to_conv;
    assign o_bandgap_routed = q.bandgap_routed;
    assign o_channel_connect = q.channel_connect;
    assign o_ref_pin_select = q.ref_pin_select;
    assign o_conv_power_down = q.conv_power_down;
    assign o_conv_clk_tick = clk_bus.tick;
    assign o_pin_analog = q.pin_analog;
    assign o_pin_pull_high_cut = q.pin_pull_high_cut;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_bandgap_selected;
        q.internal_ref_channel_sel && !q.converter_power_down;
    endsequence

    sequence s_bandgap_idle;
        !q.bandgap_enable && !i_low_voltage_reset_en && !i_low_voltage_detect_en;
    endsequence

    sequence s_div_four;
        q.conv_clock_div_sel == 3'h2 && !q.converter_power_down;
    endsequence

    sequence s_cfg2_read;
        i_psel && !i_penable && !i_pwrite && i_paddr == CFG2_ADDR;
    endsequence

    property p_bandgap_excl;
        s_bandgap_selected |=> o_bandgap_routed && o_channel_connect == 8'h00;
    endproperty
    a_bandgap_excl: assert property (p_bandgap_excl)
        else $error("bandgap routed but an input channel is still connected");

    property p_bandgap_path;
        q.bandgap_enable && !q.converter_power_down |=> o_bandgap_to_conv && o_bandgap_on;
    endproperty
    a_bandgap_path: assert property (p_bandgap_path)
        else $error("bandgap enable did not make the bandgap available");

    property p_bandgap_cut;
        !q.bandgap_enable || q.converter_power_down |=> !o_bandgap_to_conv;
    endproperty
    a_bandgap_cut: assert property (p_bandgap_cut)
        else $error("bandgap path left open after enable cleared");

    property p_bandgap_auto_off;
        s_bandgap_idle |=> !o_bandgap_on;
    endproperty
    a_bandgap_auto_off: assert property (p_bandgap_auto_off)
        else $error("bandgap left running with no user");

    property p_ref_source;
        ##1 o_ref_pin_select == $past(q.ref_source_sel);
    endproperty
    a_ref_source: assert property (p_ref_source)
        else $error("reference source does not follow its select bit");

    property p_ref_pin_takeover;
        $rose(q.ref_source_sel) |=> o_ref_pin_select && !o_channel_connect[1];
    endproperty
    a_ref_pin_takeover: assert property (p_ref_pin_takeover)
        else $error("reference pin not taken over after selection");

    property p_ref_blocks_one;
        q.ref_source_sel |=> !o_channel_connect[1];
    endproperty
    a_ref_blocks_one: assert property (p_ref_blocks_one)
        else $error("analog input one connected while reference pin in use");

    property p_div_gap;
        (o_conv_clk_tick and s_div_four) ##1 s_div_four |-> !o_conv_clk_tick;
    endproperty
    a_div_gap: assert property (p_div_gap)
        else $error("converter clock ticked too early at divide by four");

    property p_div_period;
        (o_conv_clk_tick and s_div_four) ##1 s_div_four [*3] |=> o_conv_clk_tick;
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("converter clock missed its divide by four tick");

    property p_power_down;
        q.converter_power_down |=> o_conv_power_down && !o_conv_clk_tick
            && o_channel_connect == 8'h00 && !o_bandgap_routed;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("converter still active while powered down");

    property p_reserved_zero;
        s_cfg2_read |=> o_prdata[5] == 1'b0 && o_prdata[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented configuration bits read as one");

    property p_pin_assign;
        ##1 o_pin_analog == $past(q.analog_pin_enable)
            && o_pin_pull_high_cut == o_pin_analog;
    endproperty
    a_pin_assign: assert property (p_pin_assign)
        else $error("pin analog controls do not follow the enable bits");

    sequence s_pin_write;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == PIN_ADDR;
    endsequence

    property p_pin_write;
        s_pin_write |=> q.analog_pin_enable == $past(i_pwdata[NUM_CHAN-1:0]);
    endproperty
    a_pin_write: assert property (p_pin_write)
        else $error("analog pin enable write did not land");

    property p_pin_reset;
        $past(i_sys_rst) |-> q.analog_pin_enable == PIN_RST && o_pin_analog == PIN_RST;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("analog pin enables not all set after reset");

    property p_channel_pick;
        !q.internal_ref_channel_sel && !q.converter_power_down
            && q.analog_pin_enable[q.channel_sel]
            && !(q.ref_source_sel && q.channel_sel == 3'h1)
            |=> o_channel_connect == (8'h01 << $past(q.channel_sel));
    endproperty
    a_channel_pick: assert property (p_channel_pick)
        else $error("selected input channel not the one connected");

endmodule
`default_nettype wire

// file: design/adc_sel_pkg.sv
`default_nettype none
package adc_sel_pkg;

    // APB address map, byte addresses of 32-bit words.
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CFG2_ADDR = 8'h00;
    localparam logic [7:0] PIN_ADDR  = 8'h04;
    localparam logic [7:0] CFG1_ADDR = 8'h08;
    localparam logic [7:0] STAT_ADDR = 8'h0C;

    // converter_config_two fields.
    localparam int CFG2_INT_REF_BIT = 7;
    localparam int CFG2_BG_EN_BIT   = 6;
    localparam int CFG2_REF_SRC_BIT = 4;
    localparam int CFG2_DIV_LSB     = 0;
    localparam int DIV_W            = 3;

    // converter_config_one fields.
    localparam int CFG1_PD_BIT   = 5;
    localparam int CFG1_CHAN_LSB = 0;
    localparam int CHAN_W        = 3;

    // converter_status fields.
    localparam int STAT_BG_ON_BIT   = 0;
    localparam int STAT_BG_ROUTE_BIT = 1;
    localparam int STAT_REF_PIN_BIT = 2;
    localparam int STAT_PD_BIT      = 3;
    localparam int STAT_CONN_LSB    = 8;

    // Reset values.
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] PIN_RST  = 8'hFF;
    localparam logic [7:0] CFG1_RST = 8'h20;

    // Divider, channel count and reference pin channel.
    localparam int unsigned NUM_CHAN = 8;
    localparam logic [2:0] DIV_UNDEFINED = 3'h7;
    localparam int unsigned DIV_CNT_W = 6;
    localparam int unsigned REF_PIN_CHAN = 1;

endpackage
`default_nettype wire

// file: design/conv_clk_div.sv
`default_nettype none
module conv_clk_div
    import adc_sel_pkg::*;
(
    // Clock and reset.
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    // Divider control and tick.
    conv_clk_if.div   clk_bus
);

    typedef struct packed {
        logic [DIV_CNT_W-1:0] count;
        logic                 tick;
    } div_state_t;

    div_state_t q;
    div_state_t d;
    logic [DIV_CNT_W-1:0] limit;

    always_comb begin
        d = q;
        limit = DIV_CNT_W'((7'h01 << clk_bus.div_sel) - 7'h01);
        // The undefined code and power down hold the converter clock still.
        if (!clk_bus.run || clk_bus.div_sel == DIV_UNDEFINED) begin
            d.count = '0;
            d.tick = 1'b0;
        end else if (q.count >= limit) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + 1'b1;
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clk_bus.tick = q.tick;

    property p_undefined_still;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        clk_bus.div_sel == DIV_UNDEFINED |=> !clk_bus.tick;
    endproperty
    a_undefined_still: assert property (p_undefined_still)
        else $error("converter clock ticked on undefined divide code");

endmodule
`default_nettype wire

// file: design/conv_clk_if.sv
`default_nettype none
interface conv_clk_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;

    modport ctrl (output div_sel, output run, input tick);
    modport div  (input div_sel, input run, output tick);
endinterface
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top
    import adc_sel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk;
    logic              sys_rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              lvr_en;
    logic              lvd_en;
    logic              bandgap_on;
    logic              bandgap_to_conv;
    logic              bandgap_routed;
    logic [7:0]        channel_connect;
    logic              ref_pin_select;
    logic              conv_power_down;
    logic              conv_clk_tick;
    logic [7:0]        pin_analog;
    logic [7:0]        pin_pull_high_cut;
    int                fail_count;
    int                comparisons;

    adc_input_ref_clock_select i_adc_input_ref_clock_select (
        .i_ref_clk               (ref_clk),
        .i_sys_rst               (sys_rst),
        .i_psel                  (psel),
        .i_penable               (penable),
        .i_pwrite                (pwrite),
        .i_paddr                 (paddr),
        .i_pwdata                (pwdata),
        .o_prdata                (prdata),
        .o_pready                (pready),
        .o_pslverr               (pslverr),
        .i_low_voltage_reset_en  (lvr_en),
        .i_low_voltage_detect_en (lvd_en),
        .o_bandgap_on            (bandgap_on),
        .o_bandgap_to_conv       (bandgap_to_conv),
        .o_bandgap_routed        (bandgap_routed),
        .o_channel_connect       (channel_connect),
        .o_ref_pin_select        (ref_pin_select),
        .o_conv_power_down       (conv_power_down),
        .o_conv_clk_tick         (conv_clk_tick),
        .o_pin_analog            (pin_analog),
        .o_pin_pull_high_cut     (pin_pull_high_cut)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        `CHK("pready", 1'b1, pready)
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, addr, wd, rd, err);
    endtask

    task automatic rchk(input string nm, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, addr, 32'h0000_0000, rd, err);
        `CHK(nm, exp, rd)
        `CHK("pslverr", 1'b0, err)
    endtask

    // Front-end outputs trail the register by one cycle; three edges is ample.
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rchk("cfg2 reset", CFG2_ADDR, 32'h0000_0000);
        rchk("pin reset", PIN_ADDR, 32'h0000_00FF);
        rchk("cfg1 reset", CFG1_ADDR, 32'h0000_0020);
        `CHK("pin_analog", 8'hFF, pin_analog)
        `CHK("pull_cut", 8'hFF, pin_pull_high_cut)
        `CHK("power_down", 1'b1, conv_power_down)
        `CHK("connect", 8'h00, channel_connect)
    endtask

    task automatic t_unused_bits();
        logic [31:0] rd;
        logic        err;
        wreg(CFG2_ADDR, 32'h0000_0040);
        wreg(CFG2_ADDR, 32'hFFFF_FFFF);
        rchk("cfg2 unused", CFG2_ADDR, 32'h0000_00D7);
        wreg(CFG2_ADDR, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'h0000_00FF, rd, err);
        `CHK("unmapped wr err", 1'b1, err)
        apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
        `CHK("unmapped rd err", 1'b1, err)
        `CHK("unmapped rd", 32'h0000_0000, rd)
    endtask

    task automatic t_channels();
        for (int c = 0; c < 8; c++) begin
            wreg(CFG1_ADDR, 32'(c));
            settle();
            `CHK("channel", 8'h01 << c, channel_connect)
        end
    endtask

    task automatic t_ref_pin();
        wreg(CFG1_ADDR, 32'h0000_0001);
        wreg(CFG2_ADDR, 32'h0000_0010);
        settle();
        `CHK("ref_pin", 1'b1, ref_pin_select)
        `CHK("ch1 blocked", 8'h00, channel_connect)
        wreg(CFG1_ADDR, 32'h0000_0002);
        settle();
        `CHK("ch2 free", 8'h04, channel_connect)
        wreg(CFG2_ADDR, 32'h0000_0000);
        wreg(CFG1_ADDR, 32'h0000_0001);
        settle();
        `CHK("supply ref", 1'b0, ref_pin_select)
        `CHK("ch1 back", 8'h02, channel_connect)
    endtask

    task automatic t_bandgap();
        wreg(CFG2_ADDR, 32'h0000_0040);
        settle();
        `CHK("bg_on", 1'b1, bandgap_on)
        `CHK("bg_to_conv", 1'b1, bandgap_to_conv)
        `CHK("not routed", 1'b0, bandgap_routed)
        wreg(CFG2_ADDR, 32'h0000_00C0);
        settle();
        `CHK("routed", 1'b1, bandgap_routed)
        `CHK("inputs cut", 8'h00, channel_connect)
        wreg(STAT_ADDR, 32'hFFFF_FFFF);
        rchk("status", STAT_ADDR, 32'h0000_0003);
        wreg(CFG2_ADDR, 32'h0000_0000);
        settle();
        `CHK("bg off", 1'b0, bandgap_on)
        `CHK("bg path off", 1'b0, bandgap_to_conv)
        @(posedge ref_clk);
        lvr_en <= 1'b1;
        settle();
        `CHK("bg on lvr", 1'b1, bandgap_on)
        lvr_en <= 1'b0;
        lvd_en <= 1'b1;
        settle();
        `CHK("bg on lvd", 1'b1, bandgap_on)
        lvd_en <= 1'b0;
        wreg(CFG2_ADDR, 32'h0000_0040);
        wreg(CFG1_ADDR, 32'h0000_0021);
        settle();
        `CHK("bg off in pd", 1'b0, bandgap_on)
        `CHK("pd", 1'b1, conv_power_down)
        `CHK("pd cut", 8'h00, channel_connect)
        rchk("status pd", STAT_ADDR, 32'h0000_0008);
        wreg(CFG2_ADDR, 32'h0000_0000);
    endtask

    task automatic t_pins();
        wreg(CFG1_ADDR, 32'h0000_0002);
        wreg(PIN_ADDR, 32'h0000_00FB);
        settle();
        `CHK("pin_analog", 8'hFB, pin_analog)
        `CHK("pull_cut", 8'hFB, pin_pull_high_cut)
        `CHK("digital pin", 8'h00, channel_connect)
        rchk("pin reg", PIN_ADDR, 32'h0000_00FB);
        wreg(PIN_ADDR, 32'h0000_00FF);
    endtask

    task automatic t_divider();
        int n;
        wreg(CFG1_ADDR, 32'h0000_0000);
        for (int code = 0; code < 9; code++) begin
            if (code == 8) wreg(CFG1_ADDR, 32'h0000_0020);
            wreg(CFG2_ADDR, 32'(code == 8 ? 0 : code));
            repeat (4) @(posedge ref_clk);
            n = 0;
            for (int i = 0; i < 128; i++) begin
                @(posedge ref_clk);
                if (conv_clk_tick === 1'b1) n++;
            end
            `CHK("ticks", (code >= 7) ? 0 : (128 >> code), n)
        end
    endtask

    initial begin
        fail_count  = 0;
        comparisons = 0;
        sys_rst     = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = 32'h0000_0000;
        lvr_en      = 1'b0;
        lvd_en      = 1'b0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_unused_bits();
        t_channels();
        t_ref_pin();
        t_bandgap();
        t_pins();
        t_divider();
        conclude();
    end

    initial begin
        #200000;
        $display("ERROR watchdog expired");
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
